// ===== pkg/adcsq_pkg.sv
// package: register map, field layout, reset values and timing for the converter sequencer
package adcsq_pkg;
  // register offsets (byte addresses on the plain register port)
  localparam logic [7:0] OFF_STATUS_CONTROL = 8'h3c;
  localparam logic [7:0] OFF_RESULT         = 8'h3d;
  localparam logic [7:0] OFF_CLOCK          = 8'h3e;
  localparam logic [7:0] OFF_PORT_DATA      = 8'h3f;
  localparam logic [7:0] OFF_PORT_DIR       = 8'h40;
  localparam logic [7:0] OFF_PORT_PINS      = 8'h41;

  // status and control fields
  localparam int BIT_DONE     = 7;
  localparam int BIT_IRQ_EN   = 6;
  localparam int BIT_CONT     = 5;
  localparam int CH_LSB       = 0;
  localparam int CH_W         = 5;

  // clock register fields
  localparam int DIV_LSB      = 5;
  localparam int BIT_CLK_SRC  = 4;

  // reset values
  localparam logic [4:0] CH_RESET    = 5'h1f;
  localparam logic [2:0] DIV_RESET   = 3'h0;

  // channel codes
  localparam logic [4:0] CH_LAST_PIN = 5'h07;
  localparam logic [4:0] CH_REF_HIGH = 5'h1d;
  localparam logic [4:0] CH_REF_LOW  = 5'h1e;
  localparam logic [4:0] CH_OFF      = 5'h1f;

  // result codes for the references
  localparam logic [7:0] CODE_FULL   = 8'hff;
  localparam logic [7:0] CODE_ZERO   = 8'h00;

  // conversion timing in converter clock ticks: sample phase then 8 bit trials
  localparam int SAMPLE_TICKS = 8;
  localparam int CONV_BITS    = 8;
  localparam logic [4:0] TICKS_PER_CONV = 5'd16;

  // sequencer states, gray coded along idle -> sample -> convert -> finish
  typedef enum logic [1:0]
  {
    ADCSQ_IDLE    = 2'b00,
    ADCSQ_SAMPLE  = 2'b01,
    ADCSQ_CONVERT = 2'b11,
    ADCSQ_FINISH  = 2'b10
  } adcsq_state_e;
endpackage

// ===== pkg/adcsq_tick_if.sv
// interface: converter clock tick and its configuration between prescaler and sequencer
`timescale 1ns/1ps
interface adcsq_tick_if;
  logic       src_bus;
  logic [2:0] div_code;
  logic       run;
  logic       tick;
  modport gen (input src_bus, input div_code, input run, output tick);
  modport use_tick (output src_bus, output div_code, output run, input tick);
endinterface

// ===== core/adcsq_prescaler.sv
// converter clock prescaler: picks the source and divides it into a one-cycle tick
`timescale 1ns/1ps
module adcsq_prescaler
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic xtal_tick,
  adcsq_tick_if.gen tk
);
  logic [3:0] cnt_r;
  logic       src_evt;
  logic [3:0] limit;

  // source select: bus clock is every edge, crystal is an edge-qualified strobe
  assign src_evt = tk.src_bus ? 1'b1 : xtal_tick;

  // any code with the top bit set divides by sixteen
  always_comb
  begin
    unique case (tk.div_code)
      3'h0:    limit = 4'h0;
      3'h1:    limit = 4'h1;
      3'h2:    limit = 4'h3;
      3'h3:    limit = 4'h7;
      default: limit = 4'hf;
    endcase
  end

  // divider counter; held cleared while idle so a new start has a clean phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r   <= 4'h0;
      tk.tick <= 1'b0;
    end
    else if (!tk.run)
    begin
      cnt_r   <= 4'h0;
      tk.tick <= 1'b0;
    end
    else if (src_evt)
    begin
      tk.tick <= (cnt_r >= limit);
      cnt_r   <= (cnt_r >= limit) ? 4'h0 : cnt_r + 4'h1;
    end
    else
      tk.tick <= 1'b0;
  end
endmodule

// ===== core/adcsq_top.sv
// converter sequencer: registers, port pin claim, successive-approximation control
// What this block does
// - the selected channel pin is forced to analog input, port writes ignored
// - port pin reads return zero for the pin the converter claims
// - result is unsigned 8-bit; high reference ff, low reference 00
// - any status/control write outside stop with a channel other than all ones starts a conversion of 16 or 17 clocks
// - continuous mode restarts after each conversion, overwriting the result
// - without continuous mode exactly one conversion per write
// - interrupts off: done flag set at end, cleared by result read or reset
// - interrupts on: done flag reads zero, request raised each end
// - request withdrawn on result read or status/control write
// - 5-bit channel field: 0-7 pins, 29 high ref, 30 low ref
// - all-ones channel code powers down and performs no conversions
// - reset clears enable and continuous, sets channel all ones
// - reserved channel codes give an undefined result
// - wait mode keeps converting; enabled request can wake the core
// - stop aborts pending conversion; a continuous run restarts after stop exit
// - result register loads the new code at each completion
// - 3-bit divider: 1,2,4,8, top bit set gives 16
// - source select: set is bus clock, clear is crystal; reset crystal
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module adcsq_top
#(
  parameter int PINS = 8
)
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [7:0]             rdata,
  input  wire logic              xtal_clk,
  input  wire logic              stop_mode,
  input  wire logic              cmp_high,
  output logic [7:0]             dac_code,
  output logic [4:0]             mux_sel,
  output logic                   analog_pd,
  output logic                   conv_irq,
  input  wire logic [PINS-1:0]   port_pins_in,
  output logic [PINS-1:0]        port_pins_out,
  output logic [PINS-1:0]        port_pins_oe_n,
  output logic [PINS-1:0]        analog_sel
);
  initial
    if (PINS != 8)
      $error("adcsq_top serves exactly eight shared pins");

  // register state
  logic                 irq_en_r;
  logic                 cont_r;
  logic [4:0]           chan_r;
  logic [2:0]           div_r;
  logic                 src_bus_r;
  logic [7:0]           result_r;
  logic                 done_r;
  logic [PINS-1:0]      port_data_r;
  logic [PINS-1:0]      port_dir_r;

  // sequencer state
  adcsq_pkg::adcsq_state_e state_r;
  logic [3:0]           tcnt_r;
  logic [2:0]           bit_r;
  logic                 conv_end;
  logic [7:0]           conv_code;

  // pin, crystal and stop synchronisers
  logic [PINS-1:0]      pin_s1_r;
  logic [PINS-1:0]      pin_s2_r;
  logic [PINS-1:0]      pin_s3_r;
  logic [PINS-1:0]      pin_val_r;
  logic                 xt_s1_r;
  logic                 xt_s2_r;
  logic                 xt_s3_r;
  logic                 xt_lvl_r;
  logic                 xtal_tick;
  logic                 stop_s1_r;
  logic                 stop_s2_r;
  logic                 stop_s3_r;
  logic                 stop_r;
  logic                 stop_exit;

  logic                 wr_ctrl;
  logic                 rd_result;
  logic [PINS-1:0]      claim;
  logic                 powered_off;

  adcsq_tick_if tk ();

  // shared decode: which pin (one-hot) a channel code claims
  function automatic logic [PINS-1:0] pin_claim(input logic [4:0] ch);
    logic [PINS-1:0] m;
    m = '0;
    if (ch <= adcsq_pkg::CH_LAST_PIN)
      m[ch[2:0]] = 1'b1;
    return m;
  endfunction

  assign wr_ctrl     = wr && (addr == adcsq_pkg::OFF_STATUS_CONTROL);
  assign rd_result   = rd && (addr == adcsq_pkg::OFF_RESULT);
  assign claim       = pin_claim(chan_r);
  assign powered_off = (chan_r == adcsq_pkg::CH_OFF);

  // three-stage synchronisers; a change counts when stages two and three agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_r  <= '0;
      pin_s2_r  <= '0;
      pin_s3_r  <= '0;
      pin_val_r <= '0;
      xt_s1_r   <= 1'b0;
      xt_s2_r   <= 1'b0;
      xt_s3_r   <= 1'b0;
      xt_lvl_r  <= 1'b0;
      stop_s1_r <= 1'b0;
      stop_s2_r <= 1'b0;
      stop_s3_r <= 1'b0;
      stop_r    <= 1'b0;
    end
    else
    begin
      pin_s1_r  <= port_pins_in;
      pin_s2_r  <= pin_s1_r;
      pin_s3_r  <= pin_s2_r;
      pin_val_r <= (pin_val_r & (pin_s2_r ^ pin_s3_r)) | (pin_s3_r & ~(pin_s2_r ^ pin_s3_r));
      xt_s1_r   <= xtal_clk;
      xt_s2_r   <= xt_s1_r;
      xt_s3_r   <= xt_s2_r;
      if (xt_s2_r == xt_s3_r)
        xt_lvl_r <= xt_s3_r;
      stop_s1_r <= stop_mode;
      stop_s2_r <= stop_s1_r;
      stop_s3_r <= stop_s2_r;
      if (stop_s2_r == stop_s3_r)
        stop_r <= stop_s3_r;
    end
  end

  // crystal rising edge strobe; leaving stop restarts only a continuous run
  assign xtal_tick = (xt_s2_r == xt_s3_r) && xt_s3_r && !xt_lvl_r;
  assign stop_exit = stop_r && (stop_s2_r == stop_s3_r) && !stop_s3_r && cont_r && !powered_off;

  // control fields; reset powers off, the write-reserved done position is not stored
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_en_r <= 1'b0;
      cont_r   <= 1'b0;
      chan_r   <= adcsq_pkg::CH_RESET;
    end
    else if (wr_ctrl)
    begin
      irq_en_r <= wdata[adcsq_pkg::BIT_IRQ_EN];
      cont_r   <= wdata[adcsq_pkg::BIT_CONT];
      chan_r   <= wdata[adcsq_pkg::CH_LSB +: adcsq_pkg::CH_W];
    end
  end

  // clock configuration register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r     <= adcsq_pkg::DIV_RESET;
      src_bus_r <= 1'b0;
    end
    else if (wr && addr == adcsq_pkg::OFF_CLOCK)
    begin
      div_r     <= wdata[adcsq_pkg::DIV_LSB +: 3];
      src_bus_r <= wdata[adcsq_pkg::BIT_CLK_SRC];
    end
  end

  // port output and direction registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_data_r <= '0;
      port_dir_r  <= '0;
    end
    else
    begin
      if (wr && addr == adcsq_pkg::OFF_PORT_DATA)
        port_data_r <= wdata[PINS-1:0];
      if (wr && addr == adcsq_pkg::OFF_PORT_DIR)
        port_dir_r <= wdata[PINS-1:0];
    end
  end

  // pin drive: a claimed pin is released to analog whatever the port holds
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_pins_out  <= '0;
      port_pins_oe_n <= '1;
      analog_sel     <= '0;
    end
    else
    begin
      port_pins_out  <= port_data_r & ~claim;
      port_pins_oe_n <= ~(port_dir_r & ~claim);
      analog_sel     <= claim;
    end
  end

  // prescaler runs only while a conversion is under way
  assign tk.src_bus  = src_bus_r;
  assign tk.div_code = div_r;
  assign tk.run      = (state_r != adcsq_pkg::ADCSQ_IDLE);

  adcsq_prescaler u_presc
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .xtal_tick (xtal_tick),
    .tk        (tk)
  );

  // final code; references are forced to their rails, reserved codes pass the raw trial
  always_comb
  begin
    if (chan_r == adcsq_pkg::CH_REF_HIGH)
      conv_code = adcsq_pkg::CODE_FULL;
    else if (chan_r == adcsq_pkg::CH_REF_LOW)
      conv_code = adcsq_pkg::CODE_ZERO;
    else
      conv_code = dac_code;
  end

  assign conv_end = (state_r == adcsq_pkg::ADCSQ_FINISH) && tk.tick;

  // sequencer: 8 sample ticks + 8 bit trials + 1 finish tick = 17 ticks; on the crystal the start lands mid-tick,
  // so a conversion spans 16 to 17 converter clocks, exactly 17 on the bus clock. stop or power-off abort.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= adcsq_pkg::ADCSQ_IDLE;
      tcnt_r  <= 4'h0;
      bit_r   <= 3'h7;
      dac_code <= 8'h00;
    end
    else if ((stop_r && !stop_exit) || (wr_ctrl && wdata[4:0] == adcsq_pkg::CH_OFF))
    begin
      state_r <= adcsq_pkg::ADCSQ_IDLE;
    end
    else if (wr_ctrl || stop_exit)
    begin
      state_r  <= adcsq_pkg::ADCSQ_SAMPLE;
      tcnt_r   <= 4'h0;
      bit_r    <= 3'h7;
      dac_code <= 8'h80;
    end
    else if (tk.tick)
    begin
      unique case (state_r)
        adcsq_pkg::ADCSQ_IDLE: state_r <= adcsq_pkg::ADCSQ_IDLE;
        adcsq_pkg::ADCSQ_SAMPLE:
        begin
          tcnt_r <= tcnt_r + 4'h1;
          if (tcnt_r == 4'(adcsq_pkg::SAMPLE_TICKS - 1))
            state_r <= adcsq_pkg::ADCSQ_CONVERT;
        end
        adcsq_pkg::ADCSQ_CONVERT:
        begin
          // keep the trial bit when the input sits at or above the dac level
          dac_code[bit_r] <= cmp_high;
          if (bit_r != 3'h0)
            dac_code[bit_r - 3'h1] <= 1'b1;
          bit_r <= bit_r - 3'h1;
          if (bit_r == 3'h0)
            state_r <= adcsq_pkg::ADCSQ_FINISH;
        end
        adcsq_pkg::ADCSQ_FINISH:
        begin
          tcnt_r <= 4'h0;
          bit_r  <= 3'h7;
          dac_code <= 8'h80;
          // continuous mode goes straight into the next sample
          state_r <= cont_r ? adcsq_pkg::ADCSQ_SAMPLE
                            : adcsq_pkg::ADCSQ_IDLE;
        end
      endcase
    end
  end

  // result register overwritten at every completion, read or not
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      result_r <= 8'h00;
    else if (conv_end)
      result_r <= conv_code;
  end

  // done flag: set beats the clearing read; never set with interrupts on
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      done_r <= 1'b0;
    else if (conv_end && !irq_en_r)
      done_r <= 1'b1;
    else if (rd_result || irq_en_r)
      done_r <= 1'b0;
  end

  // interrupt request; it keeps working in wait mode as nothing here gates it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      conv_irq <= 1'b0;
    else if (conv_end && irq_en_r)
      conv_irq <= 1'b1;
    else if (rd_result || wr_ctrl)
      conv_irq <= 1'b0;
  end

  // analog front end drive
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mux_sel   <= adcsq_pkg::CH_RESET;
      analog_pd <= 1'b1;
    end
    else
    begin
      mux_sel   <= chan_r;
      analog_pd <= powered_off;
    end
  end

  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (!rd)
      rdata <= 8'h00;
    else
      unique case (addr)
        adcsq_pkg::OFF_STATUS_CONTROL:
          rdata <= {done_r && !irq_en_r, irq_en_r, cont_r, chan_r};
        adcsq_pkg::OFF_RESULT:
          rdata <= result_r;
        adcsq_pkg::OFF_CLOCK:
          rdata <= {div_r, src_bus_r, 4'h0};
        adcsq_pkg::OFF_PORT_DATA:
          rdata <= port_data_r;
        adcsq_pkg::OFF_PORT_DIR:
          rdata <= port_dir_r;
        adcsq_pkg::OFF_PORT_PINS:
          rdata <= pin_val_r & ~claim;
        default:
          rdata <= 8'h00;
      endcase
  end
endmodule

// ===== verif/adcsq_chk.sv
// checker: port-level timing relations of the converter sequencer
`timescale 1ns/1ps
module adcsq_chk
#(
  parameter int PINS = 8
)
(
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic [7:0]      addr,
  input wire logic [7:0]      wdata,
  input wire logic            wr,
  input wire logic            rd,
  input wire logic [7:0]      rdata,
  input wire logic            stop_mode,
  input wire logic            analog_pd,
  input wire logic            conv_irq,
  input wire logic [PINS-1:0] port_pins_out,
  input wire logic [PINS-1:0] port_pins_oe_n,
  input wire logic [PINS-1:0] analog_sel
);
  logic [6:0] ctl_r;

  // shadow of the written control bits; reset leaves the converter off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctl_r <= 7'h1f;
    else if (wr && addr == adcsq_pkg::OFF_STATUS_CONTROL)
      ctl_r <= wdata[6:0];
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // read data only in the cycle after a read strobe
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_ctl_readback: assert property ($past(rd && addr == adcsq_pkg::OFF_STATUS_CONTROL)
    |-> rdata[6:0] == $past(ctl_r)) else $error("control readback wrong");
  a_done_masked: assert property ($past(rd && addr == 8'h3c && ctl_r[6])
    |-> !rdata[7]) else $error("done flag visible with interrupts on");
  a_claim_no_drive: assert property ((analog_sel & ~port_pins_oe_n) == '0)
    else $error("claimed pin driven");
  a_claim_out_zero: assert property ((analog_sel & port_pins_out) == '0)
    else $error("claimed pin output not zero");
  a_sel_one_pin: assert property ($onehot0(analog_sel))
    else $error("more than one pin claimed");
  a_pd_no_conv: assert property (analog_pd && $past(analog_pd) |-> !$rose(conv_irq))
    else $error("conversion finished while powered off");
  a_stop_no_conv: assert property (stop_mode [*8] |-> !$rose(conv_irq))
    else $error("conversion finished in stop");
  a_min_conv_time: assert property ((wr && addr == 8'h3c) |=> !$rose(conv_irq) [*8])
    else $error("conversion ended too early");
  a_irq_wr_clear: assert property ((wr && addr == 8'h3c) |=> !conv_irq)
    else $error("request kept after control write");
  a_irq_rd_clear: assert property ((rd && addr == adcsq_pkg::OFF_RESULT && !ctl_r[5])
    |=> !conv_irq) else $error("request kept after result read");
endmodule

// ===== verif/adcsq_tb_top.sv
// testbench: register-driven scenarios for the converter sequencer
`timescale 1ns/1ps
module adcsq_tb_top;
  logic       clk;
  logic       rst_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       xtal_clk;
  logic       stop_mode;
  logic       cmp_high;
  logic [7:0] dac_code;
  logic [4:0] mux_sel;
  logic       analog_pd;
  logic       conv_irq;
  logic [7:0] port_pins_in;
  logic [7:0] port_pins_out;
  logic [7:0] port_pins_oe_n;
  logic [7:0] analog_sel;
  logic [7:0] ain;
  logic [7:0] rv;
  logic [2:0] xdiv;
  logic [7:0] pdat;
  logic [7:0] pdir;
  int         miscompares;
  int         tests_run;
  int         cyc;

  adcsq_top dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .xtal_clk(xtal_clk), .stop_mode(stop_mode), .cmp_high(cmp_high),
    .dac_code(dac_code), .mux_sel(mux_sel), .analog_pd(analog_pd), .conv_irq(conv_irq),
    .port_pins_in(port_pins_in), .port_pins_out(port_pins_out),
    .port_pins_oe_n(port_pins_oe_n), .analog_sel(analog_sel));

  // ideal comparator against the analog input level
  assign cmp_high = (ain >= dac_code);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // crystal stand-in, one rising edge every 8 bus cycles, well under clk/4
  always @(posedge clk)
  begin
    xdiv <= xdiv + 3'd1;
    xtal_clk <= xdiv[2];
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= (a == adcsq_pkg::OFF_STATUS_CONTROL) ? {1'b0, d[6:0]} : d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read answer is sampled 1 ns after the edge, while it stands
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_done();
    int k;
    k = 0;
    rv = 8'h00;
    while (rv[7] !== 1'b1 && k < 200)
    begin
      reg_rd(adcsq_pkg::OFF_STATUS_CONTROL, rv);
      k++;
    end
  endtask

  task automatic wait_irq();
    cyc = 0;
    while (conv_irq !== 1'b1 && cyc < 1000)
    begin
      @(posedge clk);
      cyc++;
    end
  endtask

  function automatic logic [7:0] claim(input int c);
    return (c < 8) ? (8'h01 << c) : 8'h00;
  endfunction

  function automatic logic [7:0] exp_code(input int c, input logic [7:0] v);
    return (c == 29) ? 8'hff : ((c == 30) ? 8'h00 : v);
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // run a divided conversion with the request enabled and bound its length
  task automatic timed_conv(input logic [7:0] clkreg, input int r);
    reg_wr(8'h3e, clkreg);
    reg_wr(8'h3c, 8'h40);
    wait_irq();
    check("conv length", {7'h0, cyc >= 15 * r && cyc <= 17 * r + 16}, 8'h01);
    reg_rd(8'h3d, rv);
  endtask

  initial
  begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    stop_mode = 1'b0;
    ain = 8'h00;
    port_pins_in = 8'h00;
    xdiv = 3'h0;
    xtal_clk = 1'b0;
    miscompares = 0;
    tests_run = 0;
    void'($urandom(32'hdff5e245));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(8'h3c, rv);
    check("ctl reset", rv, 8'h1f);
    reg_rd(8'h3e, rv);
    check("clock reset", rv, 8'h00);
    reg_rd(8'h00, rv);
    check("unmapped read", rv, 8'h00);
    check("pd reset", {7'h0, analog_pd}, 8'h01);
    $display("test reset finished");
    reg_wr(8'h3e, 8'h10);
    // every channel code except power off, single conversions
    for (int c = 0; c < 31; c++)
    begin
      @(posedge clk);
      ain <= exp_code(c, 8'($urandom));
      port_pins_in <= 8'($urandom);
      pdat = 8'($urandom);
      pdir = 8'($urandom);
      reg_wr(8'h3f, pdat);
      reg_wr(8'h40, pdir);
      reg_wr(8'h3c, 8'(c));
      repeat (3) @(posedge clk);
      #1;
      check("claimed pin", analog_sel, claim(c));
      check("pin drive", port_pins_out, pdat & ~claim(c));
      check("pin enable", port_pins_oe_n, ~(pdir & ~claim(c)));
      check("mux select", {3'h0, mux_sel}, 8'(c));
      wait_done();
      check("done set", {7'h0, rv[7]}, 8'h01);
      reg_rd(8'h3d, rv);
      if (c < 8 || c > 28)
        check("result", rv, exp_code(c, ain));
      reg_rd(8'h41, rv);
      check("pin read", rv, port_pins_in & ~claim(c));
      reg_rd(8'h3f, rv);
      check("port data", rv, pdat);
      repeat (40) @(posedge clk);
      reg_rd(8'h3c, rv);
      check("single shot", rv, 8'(c));
    end
    $display("test channels finished");
    // continuous mode refreshes the result with each new input level
    reg_wr(8'h3c, 8'h23);
    repeat (2)
    begin
      @(posedge clk);
      ain <= 8'($urandom);
      wait_done();
      reg_rd(8'h3d, rv);
      wait_done();
      reg_rd(8'h3d, rv);
      check("continuous result", rv, ain);
    end
    reg_wr(8'h3c, 8'h03);
    wait_done();
    reg_rd(8'h3d, rv);
    $display("test continuous finished");
    // interrupt mode: flag hidden, request cleared by read and by write
    reg_wr(8'h3c, 8'h43);
    wait_irq();
    check("irq raised", {7'h0, conv_irq}, 8'h01);
    reg_rd(8'h3c, rv);
    check("done hidden", rv, 8'h43);
    reg_rd(8'h3d, rv);
    check("irq read clear", {7'h0, conv_irq}, 8'h00);
    reg_wr(8'h3c, 8'h43);
    wait_irq();
    reg_wr(8'h3c, 8'h5f);
    // the request drops at the edge that takes the write; look once it has settled
    #1;
    check("irq write clear", {7'h0, conv_irq}, 8'h00);
    repeat (300) @(posedge clk);
    check("power off", {7'h0, conv_irq}, 8'h00);
    $display("test interrupt finished");
    // divider ratios on the bus clock, then divide by 1 of the crystal; results dropped,
    // so the first run after power-off serves as the settling conversion
    timed_conv(8'h10, 1);
    timed_conv(8'h30, 2);
    timed_conv(8'h50, 4);
    timed_conv(8'h70, 8);
    timed_conv(8'hf0, 16);
    timed_conv(8'h00, 8);
    $display("test divider finished");
    // stop aborts a running conversion; a later start converts again
    reg_wr(8'h3e, 8'h10);
    reg_wr(8'h3c, 8'h40);
    repeat (4) @(posedge clk);
    stop_mode <= 1'b1;
    repeat (100) @(posedge clk);
    check("stop abort", {7'h0, conv_irq}, 8'h00);
    stop_mode <= 1'b0;
    repeat (6) @(posedge clk);
    reg_wr(8'h3c, 8'h40);
    wait_irq();
    check("stop resume", {7'h0, conv_irq}, 8'h01);
    $display("test stop finished");
    print_verdict();
  end

  // watchdog sized well above the expected run of about 3600 cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule

bind adcsq_top adcsq_chk #(.PINS(PINS)) chk_u (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stop_mode(stop_mode),
  .analog_pd(analog_pd), .conv_irq(conv_irq), .port_pins_out(port_pins_out),
  .port_pins_oe_n(port_pins_oe_n), .analog_sel(analog_sel));
